// File: hw/mcrf_config_regs.sv
// Meter global setup register and the logic its upper fields steer: filter
// settling, shared pin role, software reset, voltage pairing, neutral source.
// Assumes a plain register port in the core clock domain and samples that
// arrive synchronous to core_clk with a one-cycle valid strobe.
`timescale 1ns/1ps
module mcrf_config_regs #(
   parameter int unsigned SHORT_CYCLES = mcrf_pkg::SETTLE_SHORT_CYCLES,
   parameter int unsigned LONG_CYCLES = mcrf_pkg::SETTLE_LONG_CYCLES
) (
   input wire logic core_clk,                                    // Core clock
   input wire logic reset_n,                                     // Async reset, low
   input wire logic [mcrf_pkg::ADDR_W-1:0] regAddr,              // Register address
   input wire logic [mcrf_pkg::DATA_W-1:0] regWrData,            // Write data
   input wire logic regWrite,                                    // Write strobe
   input wire logic regRead,                                     // Read strobe
   output logic [mcrf_pkg::DATA_W-1:0] regRdData,                // Read data, next cycle
   input wire logic thirdPulseIn,                                // Third energy pulse
   input wire logic captureClkIn,                                // Capture port clock
   output logic sharedPinOut,                                    // Shared pin level
   output logic captureEnable,                                   // Capture port on
   output logic softResetPulse,                                  // Software reset start
   output logic filterSettleSelect,                              // Long settling chosen
   output logic filterSettling,                                  // Power filter settling
   input wire logic sampleValid,                                 // Sample strobe
   input wire logic signed [mcrf_pkg::SAMPLE_W-1:0] currentA,    // Phase A current
   input wire logic signed [mcrf_pkg::SAMPLE_W-1:0] currentB,    // Phase B current
   input wire logic signed [mcrf_pkg::SAMPLE_W-1:0] currentC,    // Phase C current
   input wire logic signed [mcrf_pkg::SAMPLE_W-1:0] currentN,    // Neutral current
   input wire logic signed [mcrf_pkg::SAMPLE_W-1:0] voltageA,    // Phase A voltage
   input wire logic signed [mcrf_pkg::SAMPLE_W-1:0] voltageB,    // Phase B voltage
   input wire logic signed [mcrf_pkg::SAMPLE_W-1:0] voltageC,    // Phase C voltage
   output logic signed [mcrf_pkg::SUM_W-1:0] neutralRmsInput,    // Neutral rms source
   output logic [mcrf_pkg::PHASES*mcrf_pkg::SAMPLE_W-1:0] pairedVoltage, // C, B, A
   output logic [mcrf_pkg::PAIR_ALL_W-1:0] pairedIndex,          // Voltage index per phase
   output logic pairedValid                                      // Paired samples valid
);

   // Stored fields of global_setup
   logic [mcrf_pkg::LOWER_W-1:0] lowerBits_q;
   logic filterSettleSelect_q;
   logic captureEnable_q;
   logic [mcrf_pkg::PAIR_ALL_W-1:0] voltagePairing_q;
   logic neutralSourceSelect_q;

   // Write decode and soft reset
   logic setupWrite;
   logic softResetWrite;
   logic softResetPulse_q;
   logic settleRestart;

   // Read path
   logic [mcrf_pkg::DATA_W-1:0] setupView;
   logic [mcrf_pkg::DATA_W-1:0] statusView;
   logic [mcrf_pkg::DATA_W-1:0] readValue;
   logic [mcrf_pkg::DATA_W-1:0] regRdData_q;

   // Pin, datapath and timer signals
   logic sharedPin_q;
   logic captureEnableOut_q;
   logic signed [mcrf_pkg::SUM_W-1:0] currentSum;
   logic signed [mcrf_pkg::SUM_W-1:0] neutralRms_q;
   logic [mcrf_pkg::PAIR_ALL_W-1:0] voltIndex;
   logic [mcrf_pkg::PHASES*mcrf_pkg::SAMPLE_W-1:0] voltageBus;
   logic [mcrf_pkg::PHASES*mcrf_pkg::SAMPLE_W-1:0] pairedVoltage_q;
   logic pairedValid_q;
   logic settling;

   // Address decode of writes
   always_comb begin
      setupWrite = 1'h0;
      if (regWrite && regAddr == mcrf_pkg::SETUP_ADDR) begin
         setupWrite = 1'h1;
      end
   end

   // A write with the soft reset bit set starts a software reset
   assign softResetWrite = setupWrite && regWrData[mcrf_pkg::SOFT_RESET_BIT];

   // Any setup write or soft reset restarts the power filter settling
   assign settleRestart = setupWrite;

   // Lower fields: stored only, reserved bit 2 kept at zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lowerBits_q <= mcrf_pkg::LOWER_RESET;
      end else if (softResetWrite) begin
         lowerBits_q <= mcrf_pkg::LOWER_RESET;
      end else if (setupWrite) begin
         lowerBits_q <= regWrData[mcrf_pkg::LOWER_MSB:0] & mcrf_pkg::LOWER_KEEP_MASK;
      end
   end

   // Filter settling select, bit 5
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         filterSettleSelect_q <= mcrf_pkg::SETTLE_SEL_RESET;
      end else if (softResetWrite) begin
         filterSettleSelect_q <= mcrf_pkg::SETTLE_SEL_RESET;
      end else if (setupWrite) begin
         filterSettleSelect_q <= regWrData[mcrf_pkg::SETTLE_SEL_BIT];
      end
   end

   // Capture port enable, bit 6
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         captureEnable_q <= mcrf_pkg::CAPTURE_EN_RESET;
      end else if (softResetWrite) begin
         captureEnable_q <= mcrf_pkg::CAPTURE_EN_RESET;
      end else if (setupWrite) begin
         captureEnable_q <= regWrData[mcrf_pkg::CAPTURE_EN_BIT];
      end
   end

   // Voltage pairing codes, bits 13 to 8
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         voltagePairing_q <= mcrf_pkg::PAIR_RESET;
      end else if (softResetWrite) begin
         voltagePairing_q <= mcrf_pkg::PAIR_RESET;
      end else if (setupWrite) begin
         voltagePairing_q <= regWrData[mcrf_pkg::PAIR_LSB +: mcrf_pkg::PAIR_ALL_W];
      end
   end

   // Neutral source select, bit 14
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         neutralSourceSelect_q <= mcrf_pkg::NEUTRAL_SEL_RESET;
      end else if (softResetWrite) begin
         neutralSourceSelect_q <= mcrf_pkg::NEUTRAL_SEL_RESET;
      end else if (setupWrite) begin
         neutralSourceSelect_q <= regWrData[mcrf_pkg::NEUTRAL_SEL_BIT];
      end
   end

   // Soft reset start pulse, one cycle; the bit itself is never stored
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         softResetPulse_q <= 1'h0;
      end else begin
         softResetPulse_q <= softResetWrite;
      end
   end

   // Read image of global_setup; soft reset and reserved bits read zero
   always_comb begin
      setupView = '0;
      setupView[mcrf_pkg::LOWER_MSB:0] = lowerBits_q;
      setupView[mcrf_pkg::SETTLE_SEL_BIT] = filterSettleSelect_q;
      setupView[mcrf_pkg::CAPTURE_EN_BIT] = captureEnable_q;
      setupView[mcrf_pkg::SOFT_RESET_BIT] = 1'h0;
      setupView[mcrf_pkg::PAIR_LSB +: mcrf_pkg::PAIR_ALL_W] = voltagePairing_q;
      setupView[mcrf_pkg::NEUTRAL_SEL_BIT] = neutralSourceSelect_q;
      setupView[mcrf_pkg::RESERVED_BIT] = 1'h0;
   end

   // Read image of setup_status: the block's live state
   always_comb begin
      statusView = '0;
      statusView[mcrf_pkg::STAT_SETTLING_BIT] = settling;
      statusView[mcrf_pkg::STAT_LONG_BIT] = filterSettleSelect_q;
      statusView[mcrf_pkg::STAT_CAPTURE_BIT] = captureEnableOut_q;
      statusView[mcrf_pkg::STAT_NEUTRAL_BIT] = neutralSourceSelect_q;
   end

   // Read address decode; unmapped addresses read zero
   always_comb begin
      if (regAddr == mcrf_pkg::SETUP_ADDR) begin
         readValue = setupView;
      end else if (regAddr == mcrf_pkg::STATUS_ADDR) begin
         readValue = statusView;
      end else begin
         readValue = '0;
      end
   end

   // Read data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData_q <= '0;
      end else if (regRead) begin
         regRdData_q <= readValue;
      end else begin
         regRdData_q <= '0;
      end
   end

   // Shared pin: third pulse output or capture port clock
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sharedPin_q <= 1'h0;
         captureEnableOut_q <= mcrf_pkg::CAPTURE_EN_RESET;
      end else begin
         captureEnableOut_q <= captureEnable_q;
         if (captureEnable_q) begin
            sharedPin_q <= captureClkIn;
         end else begin
            sharedPin_q <= thirdPulseIn;
         end
      end
   end

   // Instantaneous sum of the three phase currents
   assign currentSum = SUM_EXT(currentA) + SUM_EXT(currentB) + SUM_EXT(currentC);

   // Sign extension of a sample to the sum width
   function automatic logic signed [mcrf_pkg::SUM_W-1:0] SUM_EXT(
      input logic signed [mcrf_pkg::SAMPLE_W-1:0] sample
   );
      SUM_EXT = mcrf_pkg::SUM_W'(sample);
   endfunction : SUM_EXT

   // Neutral rms source: measured neutral or phase current sum
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         neutralRms_q <= '0;
      end else if (sampleValid) begin
         if (neutralSourceSelect_q) begin
            neutralRms_q <= currentSum;
         end else begin
            neutralRms_q <= SUM_EXT(currentN);
         end
      end
   end

   // Voltage index decoder for each phase current
   mcrf_pair_map u_pair_map (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .pairCodes(voltagePairing_q),
      .voltIndex(voltIndex)
   );

   // Voltage samples gathered as A, B, C from the low end
   assign voltageBus = {voltageC, voltageB, voltageA};

   genvar ph;

   // Voltage paired with each phase current, per phase
   generate
      for (ph = 0; ph < mcrf_pkg::PHASES; ph++) begin : g_pair
         logic [mcrf_pkg::PAIR_W-1:0] sel;
         assign sel = voltIndex[ph*mcrf_pkg::PAIR_W +: mcrf_pkg::PAIR_W];

         // Sample of the selected voltage on each valid strobe
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               pairedVoltage_q[ph*mcrf_pkg::SAMPLE_W +: mcrf_pkg::SAMPLE_W] <= '0;
            end else if (sampleValid) begin
               pairedVoltage_q[ph*mcrf_pkg::SAMPLE_W +: mcrf_pkg::SAMPLE_W] <=
                  voltageBus[sel*mcrf_pkg::SAMPLE_W +: mcrf_pkg::SAMPLE_W];
            end
         end
      end
   endgenerate

   // Valid strobe follows the sample strobe by one cycle, on the same edge as the paired samples
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pairedValid_q <= 1'h0;
      end else begin
         pairedValid_q <= sampleValid;
      end
   end

   // Settling timer of the total active power filter
   mcrf_settle_timer #(
      .SHORT_CYCLES(SHORT_CYCLES),
      .LONG_CYCLES(LONG_CYCLES)
   ) u_settle_timer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .restart(settleRestart),
      .longSelect(filterSettleSelect_q),
      .settling(settling)
   );

   // Outputs straight from flip-flops
   assign regRdData = regRdData_q;
   assign sharedPinOut = sharedPin_q;
   assign captureEnable = captureEnableOut_q;
   assign softResetPulse = softResetPulse_q;
   assign filterSettleSelect = filterSettleSelect_q;
   assign filterSettling = settling;
   assign neutralRmsInput = neutralRms_q;
   assign pairedVoltage = pairedVoltage_q;
   assign pairedIndex = voltIndex;
   assign pairedValid = pairedValid_q;

endmodule : mcrf_config_regs

// File: hw/mcrf_pkg.sv
// Constants shared by the meter setup register block: offsets, field positions,
// reset values, widths and settling times.
// Assumes a single 50 MHz core clock; every user writes mcrf_pkg::name.
package mcrf_pkg;

   // Core clock rate and the derived cycles per millisecond
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;

   // Power filter settling times in milliseconds and in core clock cycles
   localparam int unsigned SETTLE_SHORT_MS = 650;
   localparam int unsigned SETTLE_LONG_MS = 1300;
   localparam int unsigned SETTLE_SHORT_CYCLES = SETTLE_SHORT_MS * CYCLES_PER_MS;
   localparam int unsigned SETTLE_LONG_CYCLES = SETTLE_LONG_MS * CYCLES_PER_MS;
   localparam int SETTLE_CNT_W = 27;

   // Register port widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;

   // Register addresses
   localparam logic [ADDR_W-1:0] SETUP_ADDR = 16'hE618;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'hE680;

   // Field positions in global_setup
   localparam int LOWER_MSB = 4;
   localparam int LOWER_W = 5;
   localparam int SETTLE_SEL_BIT = 5;
   localparam int CAPTURE_EN_BIT = 6;
   localparam int SOFT_RESET_BIT = 7;
   localparam int PAIR_LSB = 8;
   localparam int PAIR_W = 2;
   localparam int PAIR_ALL_W = 6;
   localparam int NEUTRAL_SEL_BIT = 14;
   localparam int RESERVED_BIT = 15;

   // Reset values of global_setup fields
   localparam logic [LOWER_W-1:0] LOWER_RESET = 5'h10;
   localparam logic [LOWER_W-1:0] LOWER_KEEP_MASK = 5'h1B;
   localparam logic SETTLE_SEL_RESET = 1'h0;
   localparam logic CAPTURE_EN_RESET = 1'h0;
   localparam logic NEUTRAL_SEL_RESET = 1'h0;
   localparam logic [PAIR_ALL_W-1:0] PAIR_RESET = 6'h00;

   // Pairing codes and phase indices
   localparam int PHASES = 3;
   localparam logic [PAIR_W-1:0] PAIR_RESERVED = 2'h3;
   localparam logic [PAIR_W-1:0] PAIR_DIRECT = 2'h0;

   // Bit positions in setup_status
   localparam int STAT_SETTLING_BIT = 0;
   localparam int STAT_LONG_BIT = 1;
   localparam int STAT_CAPTURE_BIT = 2;
   localparam int STAT_NEUTRAL_BIT = 3;

   // Sample widths of the current and voltage datapath
   localparam int SAMPLE_W = 24;
   localparam int SUM_W = 26;

endpackage : mcrf_pkg

// File: hw/mcrf_pair_map.sv
// Per-phase voltage pairing decoder: turns the three two-bit pairing codes into
// the index of the voltage paired with each phase current (0 A, 1 B, 2 C).
// Assumes codes come straight from the setup register; outputs are registered.
`timescale 1ns/1ps
module mcrf_pair_map (
   input wire logic core_clk,                                    // Core clock
   input wire logic reset_n,                                     // Async reset, low
   input wire logic [mcrf_pkg::PAIR_ALL_W-1:0] pairCodes,        // Codes A, B, C
   output logic [mcrf_pkg::PAIR_ALL_W-1:0] voltIndex            // Voltage per phase
);

   genvar p;

   // One decoder per phase: index is phase plus code, modulo three
   generate
      for (p = 0; p < mcrf_pkg::PHASES; p++) begin : g_phase
         localparam logic [2:0] PIDX = 3'(p);
         logic [mcrf_pkg::PAIR_W-1:0] code;
         logic [2:0] rawSum;
         logic [mcrf_pkg::PAIR_W-1:0] index;

         // Reserved code falls back to the direct pairing
         always_comb begin
            code = pairCodes[p*mcrf_pkg::PAIR_W +: mcrf_pkg::PAIR_W];
            if (code == mcrf_pkg::PAIR_RESERVED) begin
               code = mcrf_pkg::PAIR_DIRECT;
            end
            rawSum = PIDX + {1'h0, code};
            if (rawSum >= 3'(mcrf_pkg::PHASES)) begin
               index = 2'(rawSum - 3'(mcrf_pkg::PHASES));
            end else begin
               index = rawSum[1:0];
            end
         end

         // Registered index
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               voltIndex[p*mcrf_pkg::PAIR_W +: mcrf_pkg::PAIR_W] <= 2'(p);
            end else begin
               voltIndex[p*mcrf_pkg::PAIR_W +: mcrf_pkg::PAIR_W] <= index;
            end
         end
      end
   endgenerate

endmodule : mcrf_pair_map

// File: hw/mcrf_settle_timer.sv
// Settling timer of the total active power low-pass filter: reports busy for
// the short or long settling time after each restart and after reset.
// Assumes restart is a one-cycle pulse in the core clock domain.
`timescale 1ns/1ps
module mcrf_settle_timer #(
   parameter int unsigned SHORT_CYCLES = mcrf_pkg::SETTLE_SHORT_CYCLES,
   parameter int unsigned LONG_CYCLES = mcrf_pkg::SETTLE_LONG_CYCLES
) (
   input wire logic core_clk,       // Core clock
   input wire logic reset_n,        // Async reset, low
   input wire logic restart,        // Start a new settling period
   input wire logic longSelect,     // Long settling time chosen
   output logic settling            // Filter still settling
);

   logic [mcrf_pkg::SETTLE_CNT_W-1:0] count_q;
   logic [mcrf_pkg::SETTLE_CNT_W-1:0] limit;

   // Last count of the chosen settling period
   always_comb begin
      if (longSelect) begin
         limit = mcrf_pkg::SETTLE_CNT_W'(LONG_CYCLES - 1);
      end else begin
         limit = mcrf_pkg::SETTLE_CNT_W'(SHORT_CYCLES - 1);
      end
   end

   // Cycle counter, cleared on restart
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= '0;
      end else if (restart) begin
         count_q <= '0;
      end else if (settling && count_q < limit) begin
         count_q <= count_q + 1'h1;
      end
   end

   // Busy flag, set by restart and reset, dropped at the last count
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         settling <= 1'h1;
      end else if (restart) begin
         settling <= 1'h1;
      end else if (count_q >= limit) begin
         settling <= 1'h0;
      end
   end

endmodule : mcrf_settle_timer

// File: testbench/mcrf_config_properties.sv
// Concurrent checks on the ports of the meter setup register block.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module mcrf_config_properties #(
   parameter int unsigned SHORT_CYCLES = 20,
   parameter int unsigned LONG_CYCLES = 40
) (
   input wire logic core_clk, // Core clock
   input wire logic reset_n, // Async reset
   input wire logic [mcrf_pkg::ADDR_W-1:0] regAddr, // Address
   input wire logic [mcrf_pkg::DATA_W-1:0] regWrData, // Write data
   input wire logic regWrite, // Write strobe
   input wire logic regRead, // Read strobe
   input wire logic [mcrf_pkg::DATA_W-1:0] regRdData, // Read data
   input wire logic thirdPulseIn, // Pulse source
   input wire logic captureClkIn, // Clock source
   input wire logic sharedPinOut, // Shared pin
   input wire logic captureEnable, // Capture on
   input wire logic softResetPulse, // Soft reset
   input wire logic filterSettleSelect, // Long select
   input wire logic filterSettling, // Settling
   input wire logic [mcrf_pkg::PAIR_ALL_W-1:0] pairedIndex // Index per phase
);
   logic setupWr;
   logic [7:0] sinceWr_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Decoded pairing index of each of the three phases, reserved code acting as direct
   function automatic logic [5:0] pairMap(input logic [15:0] d);
      int s [3];
      for (int p = 0; p < 3; p++) begin
         s[p] = d[7] ? 0 : int'(d[8+2*p+:2]);
         s[p] = ((s[p] == 3 ? 0 : s[p]) + p) % 3;
      end
      return {2'(s[2]), 2'(s[1]), 2'(s[0])};
   endfunction : pairMap
   // Setup write decode
   assign setupWr = regWrite && regAddr == mcrf_pkg::SETUP_ADDR;
   // Cycles since release or the last setup write
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) sinceWr_q <= 8'h00;
      else if (setupWr) sinceWr_q <= 8'h01;
      else if (sinceWr_q != 8'hFF) sinceWr_q <= sinceWr_q + 8'h01;
   end
   AST_SEL_FOLLOWS: assert property (setupWr |=> filterSettleSelect ==
      ($past(regWrData[7]) ? 1'b0 : $past(regWrData[5]))) else $error("settle select wrong");
   AST_SETTLE_START: assert property (setupWr |=> filterSettling)
      else $error("settling not restarted");
   AST_SETTLE_LEN: assert property ($fell(filterSettling) |->
      int'(sinceWr_q) + 2 >= int'(filterSettleSelect ? LONG_CYCLES : SHORT_CYCLES) &&
      int'(sinceWr_q) <= int'(filterSettleSelect ? LONG_CYCLES : SHORT_CYCLES) + 1)
      else $error("settling length wrong");
   AST_CAP_EN: assert property (setupWr |-> ##2 captureEnable ==
      $past(regWrData[6] & ~regWrData[7], 2)) else $error("capture enable wrong");
   AST_PIN_CAP: assert property ($past(reset_n) && captureEnable && $past(captureEnable)
      |-> sharedPinOut == $past(captureClkIn)) else $error("pin not capture clock");
   AST_PIN_PULSE: assert property ($past(reset_n) && !captureEnable && !$past(captureEnable)
      |-> sharedPinOut == $past(thirdPulseIn)) else $error("pin not pulse output");
   AST_SRST_PULSE: assert property (setupWr && regWrData[7] |=> softResetPulse)
      else $error("soft reset not pulsed");
   AST_SRST_CAUSE: assert property (softResetPulse |-> $past(setupWr && regWrData[7]))
      else $error("stray soft reset pulse");
   AST_RD_BITS: assert property ($past(regRead && regAddr == mcrf_pkg::SETUP_ADDR)
      |-> !regRdData[7] && !regRdData[15]) else $error("reserved or reset bit reads one");
   AST_PAIR_IDX: assert property (setupWr |-> ##2 pairedIndex ==
      pairMap($past(regWrData, 2))) else $error("pairing index wrong");
endmodule : mcrf_config_properties

// File: testbench/tb_mcrf_config_regs.sv
// Self-checking bench of the meter setup register block, one task per scenario.
// Assumes shortened settling counts; the checker is bound at the foot.
`timescale 1ns/1ps
module tb_mcrf_config_regs;
   localparam int unsigned SH = 20;
   localparam int unsigned LG = 40;
   localparam logic [15:0] SA = mcrf_pkg::SETUP_ADDR;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regRdData;
   logic thirdPulseIn = 1'b0;
   logic captureClkIn = 1'b0;
   logic sharedPinOut, captureEnable, softResetPulse, filterSettleSelect, filterSettling;
   logic sampleValid = 1'b0;
   logic signed [23:0] currentA = 24'h00_0000, currentB = 24'h00_0000;
   logic signed [23:0] currentC = 24'h00_0000, currentN = 24'h00_0000;
   logic signed [23:0] voltageA = 24'h00_0000, voltageB = 24'h00_0000;
   logic signed [23:0] voltageC = 24'h00_0000;
   logic signed [25:0] neutralRmsInput;
   logic [71:0] pairedVoltage;
   logic [5:0] pairedIndex;
   logic pairedValid;
   int miscompares = 0;
   int cmpCount = 0;
   // Device under test with short settling counts
   mcrf_config_regs #(.SHORT_CYCLES(SH), .LONG_CYCLES(LG)) mcrf_config_regs_i (
      .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .thirdPulseIn(thirdPulseIn), .captureClkIn(captureClkIn), .sharedPinOut(sharedPinOut),
      .captureEnable(captureEnable), .softResetPulse(softResetPulse),
      .filterSettleSelect(filterSettleSelect), .filterSettling(filterSettling),
      .sampleValid(sampleValid), .currentA(currentA), .currentB(currentB),
      .currentC(currentC), .currentN(currentN), .voltageA(voltageA), .voltageB(voltageB),
      .voltageC(voltageC), .neutralRmsInput(neutralRmsInput), .pairedVoltage(pairedVoltage),
      .pairedIndex(pairedIndex), .pairedValid(pairedValid));
   // Clock at 50 MHz
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   task automatic stopTest();
      $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stopTest
   task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
      cmpCount++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wr
   // One-cycle read strobe, data judged in the following cycle
   task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(negedge core_clk);
      chk("regRdData", 72'(exp), 72'(regRdData));
   endtask : rdChk
   // Bounded wait for the settling flag to drop, length judged against lim
   task automatic settle(input int lim);
      int n;
      // First look half a cycle on, once a restart at this edge has landed
      @(negedge core_clk);
      n = 1;
      while (filterSettling !== 1'b0 && n < 1000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 1000) begin
         miscompares++;
         stopTest();
      end
      chk("settleLength", 72'h1, 72'(n + 2 >= lim && n <= lim + 1));
   endtask : settle
   task automatic pulse();
      @(posedge core_clk);
      sampleValid <= 1'b1;
      @(posedge core_clk);
      sampleValid <= 1'b0;
      @(negedge core_clk);
      chk("pairedValid", 72'h1, 72'(pairedValid));
   endtask : pulse
   task automatic pins(input logic clkLvl, input logic pulseLvl, input logic exp);
      @(posedge core_clk);
      captureClkIn <= clkLvl;
      thirdPulseIn <= pulseLvl;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk("sharedPinOut", 72'(exp), 72'(sharedPinOut));
   endtask : pins
   task automatic tReset();
      settle(SH);
      chk("pairedIndex", 72'h24, 72'(pairedIndex));
      chk("captureEnable", 72'h0, 72'(captureEnable));
      rdChk(SA, 16'h0010);
   endtask : tReset
   task automatic tSettle();
      wr(SA, 16'h0030);
      settle(LG);
      chk("filterSettleSelect", 72'h1, 72'(filterSettleSelect));
      rdChk(SA, 16'h0030);
      rdChk(mcrf_pkg::STATUS_ADDR, 16'h0002);
      wr(SA, 16'h0010);
      settle(SH);
   endtask : tSettle
   task automatic tCapture();
      wr(SA, 16'h0050);
      pins(1'b1, 1'b0, 1'b1);
      pins(1'b0, 1'b1, 1'b0);
      chk("captureEnable", 72'h1, 72'(captureEnable));
      wr(SA, 16'h0010);
      pins(1'b1, 1'b0, 1'b0);
      pins(1'b0, 1'b1, 1'b1);
   endtask : tCapture
   task automatic tSoftReset();
      wr(SA, 16'h4F70);
      wr(SA, 16'h4FF0);
      @(negedge core_clk);
      chk("softResetPulse", 72'h1, 72'(softResetPulse));
      @(negedge core_clk);
      chk("softResetPulse", 72'h0, 72'(softResetPulse));
      rdChk(SA, 16'h0010);
   endtask : tSoftReset
   task automatic tReserved();
      wr(SA, 16'h8014);
      rdChk(SA, 16'h0010);
      wr(16'h1234, 16'h0030);
      rdChk(SA, 16'h0010);
      rdChk(16'h1234, 16'h0000);
   endtask : tReserved
   task automatic tPairing();
      logic [23:0] v [3];
      int ia;
      v = '{24'h00_1111, 24'h00_2222, 24'h00_3333};
      @(posedge core_clk);
      voltageA <= v[0];
      voltageB <= v[1];
      voltageC <= v[2];
      for (int c = 0; c < 4; c++) begin
         wr(SA, 16'h0010 | (16'(c) << 8) | (16'(c) << 10) | (16'(c) << 12));
         ia = (c == 3) ? 0 : c;
         pulse();
         chk("pairedVoltage", {v[(ia+2)%3], v[(ia+1)%3], v[ia]}, pairedVoltage);
      end
   endtask : tPairing
   task automatic tNeutral();
      @(posedge core_clk);
      currentA <= 24'h10_0000;
      currentB <= 24'h20_0000;
      currentC <= 24'hFF_FFFB;
      currentN <= 24'hF0_0001;
      wr(SA, 16'h0010);
      pulse();
      chk("neutralRmsInput", 72'(26'h3F0_0001), 72'($unsigned(neutralRmsInput)));
      wr(SA, 16'h4010);
      pulse();
      chk("neutralRmsInput", 72'(26'h02F_FFFB), 72'($unsigned(neutralRmsInput)));
   endtask : tNeutral
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      tReset();
      tSettle();
      tCapture();
      tSoftReset();
      tReserved();
      tPairing();
      tNeutral();
      stopTest();
   end
endmodule : tb_mcrf_config_regs
bind mcrf_config_regs mcrf_config_properties #(.SHORT_CYCLES(SHORT_CYCLES),
   .LONG_CYCLES(LONG_CYCLES)) props_i (.core_clk(core_clk), .reset_n(reset_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .thirdPulseIn(thirdPulseIn), .captureClkIn(captureClkIn),
   .sharedPinOut(sharedPinOut), .captureEnable(captureEnable),
   .softResetPulse(softResetPulse), .filterSettleSelect(filterSettleSelect),
   .filterSettling(filterSettling), .pairedIndex(pairedIndex));
